// ---- spio_defines.svh ----
// Register offsets, field positions and reset values for the shared parallel I/O port
`ifndef SPIO_DEFINES_SVH
`define SPIO_DEFINES_SVH
`define SPIO_OFF_DIR      12'h000
`define SPIO_OFF_LAT      12'h004
`define SPIO_OFF_LVL      12'h008
`define SPIO_OFF_ANA      12'h00c
`define SPIO_OFF_CNEN     12'h010
`define SPIO_OFF_IRQ_STAT 12'h014
`define SPIO_OFF_IRQ_MASK 12'h018
`define SPIO_DIR_RESET    16'hffff
`define SPIO_LAT_RESET    16'h0000
`define SPIO_ANA_RESET    16'h0000
`define SPIO_CNEN_RESET   32'h0000_0000
`define SPIO_MASK_RESET   32'h0000_0000
`define SPIO_STAT_CN_BIT  0
`define SPIO_STAT_WAKE_BIT 1
`endif

// ---- spio_pkg.sv ----
// Types shared by the shared parallel I/O port
package spio_pkg;
  // Per-pin peripheral claim on the pad
  typedef struct packed {
    logic [15:0] enable;
    logic [15:0] drive;
    logic [15:0] data;
    logic [15:0] out_en;
  } spio_periph_s;
  // Pad output controls, output enable low while driving
  typedef struct packed {
    logic [15:0] data;
    logic [15:0] oe_n;
  } spio_pad_s;
  typedef enum logic [1:0] {SPIO_IDLE, SPIO_ACCESS} spio_phase_e;
endpackage

// ---- spio_port.sv ----
// Shared parallel I/O port with APB registers, analog masking and change notification
//
// Summary of operation
// - An enabled peripheral that drives a pin takes the pad driver from the port while the pin stays readable.
// - An enabled peripheral not driving a pin leaves the pad to the port logic.
// - A direction bit of one makes the pin an input, zero makes it an output driven from the latch.
// - Every direction bit comes up set after reset, so all pins start as inputs.
// - Reading the latch register returns the latch and writing it updates the latch.
// - Reading the pin-level register returns the pins and writing it updates the latch.
// - Unimplemented bit positions have direction, latch and pin level disabled and reading zero.
// - A pin shared only with an input function is a dedicated port pin with no competing output.
// - Per pin, two multiplexers pick the peripheral or the port for pad data and output enable.
// - Pins configured as analog inputs read as zero through the pin-level register.
// - A pin configured as digital input is not offered to the analog converter.
// - A change on any selected input pin raises the change interrupt.
// - Change detection works in sleep with the clock stopped.
// - Up to twenty-two change inputs are supported, each individually enabled.
`timescale 1ns/1ps
`default_nettype none
`include "spio_defines.svh"

module spio_port #(
  parameter int          NCN       = 22,
  parameter logic [15:0] IMPL_MASK = 16'hffff,
  parameter logic [15:0] INPUT_ONLY = 16'h0000
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Pads and peripherals
  input  wire logic [15:0]          pad_in,
  input  wire spio_pkg::spio_periph_s periph,
  output spio_pkg::spio_pad_s       pad,
  output logic      [15:0]          adc_source,
  // Change notification
  input  wire logic [NCN-1:0]       change_notify_input,
  input  wire logic                 sleep,
  output logic                      irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0]     pin_direction;
  logic [15:0]     output_latch;
  logic [15:0]     analog_pin_config;
  logic [NCN-1:0]  cn_enable;
  logic [1:0]      irq_status;
  logic [1:0]      irq_mask;
  logic [15:0]     lvl_s1, lvl_s2, lvl_s3;
  logic [NCN-1:0]  cn_s1, cn_s2, cn_s3, cn_prev;
  logic            wake_s1, wake_s2, wake_s3;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode, single-cycle answer in the access phase
  wire         acc      = psel & penable;
  wire         wr       = acc & pwrite;
  wire         rd       = acc & ~pwrite;
  wire         hit_dir  = paddr == `SPIO_OFF_DIR;
  wire         hit_lat  = paddr == `SPIO_OFF_LAT;
  wire         hit_lvl  = paddr == `SPIO_OFF_LVL;
  wire         hit_ana  = paddr == `SPIO_OFF_ANA;
  wire         hit_cnen = paddr == `SPIO_OFF_CNEN;
  wire         hit_stat = paddr == `SPIO_OFF_IRQ_STAT;
  wire         hit_mask = paddr == `SPIO_OFF_IRQ_MASK;
  wire         hit_any  = hit_dir | hit_lat | hit_lvl | hit_ana | hit_cnen | hit_stat | hit_mask;
  // Analog pins read low through the pin-level path
  wire [15:0]  lvl_read = lvl_s3 & ~analog_pin_config & IMPL_MASK;
  wire [31:0]  cn_en32  = 32'(cn_enable);
  wire [31:0]  rd_mux   = hit_dir  ? {16'h0000, pin_direction & IMPL_MASK} :
                          hit_lat  ? {16'h0000, output_latch & IMPL_MASK} :
                          hit_lvl  ? {16'h0000, lvl_read} :
                          hit_ana  ? {16'h0000, analog_pin_config} :
                          hit_cnen ? cn_en32 :
                          hit_stat ? {30'h0000_0000, irq_status} :
                          hit_mask ? {30'h0000_0000, irq_mask} : 32'h0000_0000;

  // Registered answer; pready pulses on the access cycle after the setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Writes take effect on the completing edge (pready high with penable)
  wire wr_go = wr & pready & hit_any;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_direction     <= `SPIO_DIR_RESET;
      output_latch      <= `SPIO_LAT_RESET;
      analog_pin_config <= `SPIO_ANA_RESET;
      cn_enable         <= NCN'(`SPIO_CNEN_RESET);
      irq_mask          <= 2'(`SPIO_MASK_RESET);
    end
    else if (wr_go)
    begin
      if (hit_dir)
        pin_direction <= pwdata[15:0] & IMPL_MASK;
      if (hit_lat | hit_lvl)
        output_latch <= pwdata[15:0] & IMPL_MASK;
      if (hit_ana)
        analog_pin_config <= pwdata[15:0];
      if (hit_cnen)
        cn_enable <= pwdata[NCN-1:0];
      if (hit_mask)
        irq_mask <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad ownership: peripheral wins only while enabled and actively driving
  wire [15:0] periph_owns = periph.enable & periph.drive & ~INPUT_ONLY;
  wire [15:0] port_oe_n   = pin_direction | ~IMPL_MASK;
  wire [15:0] next_data   = (periph_owns & periph.data) | (~periph_owns & output_latch);
  wire [15:0] next_oe_n   = (periph_owns & ~periph.out_en) | (~periph_owns & port_oe_n);
  // Converter only sees pins set analog and left as inputs
  wire [15:0] next_adc    = analog_pin_config & pin_direction & IMPL_MASK;

  // Outputs from flops; one-cycle lag is why software pauses before reading
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad.data   <= 16'h0000;
      pad.oe_n   <= 16'hffff;
      adc_source <= 16'h0000;
    end
    else
    begin
      pad.data   <= next_data;
      pad.oe_n   <= next_oe_n;
      adc_source <= next_adc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and change-input synchronisers, three stages
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl_s1 <= 16'h0000;
      lvl_s2 <= 16'h0000;
      lvl_s3 <= 16'h0000;
      cn_s1  <= '0;
      cn_s2  <= '0;
      cn_s3  <= '0;
    end
    else
    begin
      lvl_s1 <= pad_in;
      lvl_s2 <= lvl_s1;
      lvl_s3 <= lvl_s2;
      cn_s1  <= change_notify_input;
      cn_s2  <= cn_s1;
      cn_s3  <= cn_s2;
    end
  end

  // Accept a change only where stages two and three agree
  wire [NCN-1:0] cn_stable = ~(cn_s2 ^ cn_s3);
  wire [NCN-1:0] cn_diff;
  genvar gi;
  generate
    for (gi = 0; gi < NCN; gi++)
    begin : g_cn
      assign cn_diff[gi] = cn_enable[gi] & cn_stable[gi] & (cn_s3[gi] ^ cn_prev[gi]);
    end
  endgenerate
  wire cn_event = |cn_diff;

  // Previous sample follows the agreed value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cn_prev <= '0;
    else
      cn_prev <= (cn_prev & ~cn_stable) | (cn_s3 & cn_stable);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep wake: an asynchronous latch on any enabled input mismatch, needs no clock.
  // Trade-off: combinational compare against the last clocked sample, reset once clocks return.
  wire wake_async = sleep & |(cn_enable & (change_notify_input ^ cn_prev));
  logic wake_latch;
  wire  wake_clr   = wake_s3 & ~sleep;
  always_ff @(posedge wake_async or negedge presetn or posedge wake_clr)
  begin
    if (!presetn)
      wake_latch <= 1'b0;
    else if (wake_clr)
      wake_latch <= 1'b0;
    else
      wake_latch <= 1'b1;
  end

  // Wake latch crosses into pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_s3 <= 1'b0;
    end
    else
    begin
      wake_s1 <= wake_latch;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
    end
  end
  wire wake_event = wake_s2 & ~wake_s3;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status; a read clears it, but a same-cycle event wins
  wire       stat_rd   = rd & pready & hit_stat;
  wire [1:0] ev_bits   = {wake_event, cn_event};
  wire [1:0] next_stat = (stat_rd ? 2'b00 : irq_status) | ev_bits;
  // Mask as it stands after this edge, so a mask write and the line agree at once
  wire [1:0] next_mask = (wr_go & hit_mask) ? pwdata[1:0] : irq_mask;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= 2'b00;
      irq        <= 1'b0;
    end
    else
    begin
      irq_status <= next_stat;
      irq        <= |(next_stat & next_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_cn_change;
    cn_event;
  endsequence
  sequence s_flag_up;
    ##1 irq_status[`SPIO_STAT_CN_BIT];
  endsequence

  a_dir_reset_input: assert property (@(posedge pclk) $rose(presetn) |-> pin_direction == 16'hffff)
    else $error("direction not all inputs after reset");
  a_periph_owns_pad: assert property (@(posedge pclk) disable iff (!presetn)
    (periph_owns[8] && !$changed(periph)) |=> pad.oe_n[8] == ~$past(periph.out_en[8]))
    else $error("peripheral does not own pad");
  a_port_owns_pad: assert property (@(posedge pclk) disable iff (!presetn)
    !periph_owns[0] |=> pad.oe_n[0] == $past(port_oe_n[0]) && pad.data[0] == $past(output_latch[0]))
    else $error("port does not own pad");
  a_dir_input_off: assert property (@(posedge pclk) disable iff (!presetn)
    (!periph_owns[1] && pin_direction[1]) |=> pad.oe_n[1])
    else $error("input pin is driven");
  a_lvl_write_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_go && hit_lvl) |=> output_latch == ($past(pwdata[15:0]) & IMPL_MASK))
    else $error("pin-level write missed latch");
  a_lat_readback: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_lat) |=> prdata[15:0] == $past(output_latch & IMPL_MASK))
    else $error("latch readback wrong");
  a_analog_reads_low: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_lvl) |=> (prdata[15:0] & $past(analog_pin_config)) == 16'h0000)
    else $error("analog pin reads high");
  a_digital_no_adc: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (adc_source & ~$past(analog_pin_config)) == 16'h0000)
    else $error("digital pin offered to converter");
  a_cn_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    s_cn_change |-> s_flag_up)
    else $error("change did not set flag");
  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == |(irq_status & irq_mask))
    else $error("irq not matching masked status");

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer checks; the slave never inserts a wait state
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ready_next;
    ##1 pready;
  endsequence
  sequence s_stat_clear;
    rd && pready && hit_stat;
  endsequence

  // Ready follows every setup cycle by exactly one edge
  a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup |-> s_ready_next)
    else $error("no ready after setup");
  // Ready is a pulse, so a held access never completes twice
  a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");
  // Unmapped offsets answer with an error
  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (s_setup and !hit_any) |=> pslverr)
    else $error("unmapped access without error");
  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error outside the answer cycle");
  // Read data is quiet outside the answer cycle
  a_rdata_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");

  ////////////////////////////////////////////////////////////////////////////
  // Register and pad checks
  a_dir_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_go && hit_dir) |=> pin_direction == ($past(pwdata[15:0]) & IMPL_MASK))
    else $error("direction write lost");
  // Missing bits never hold a latch value
  a_unimpl_lat_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (output_latch & ~IMPL_MASK) == 16'h0000)
    else $error("unimplemented latch bit set");
  // Missing bits are never driven by the port
  a_unimpl_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (~pad.oe_n & ~IMPL_MASK & ~$past(periph_owns)) == 16'h0000)
    else $error("unimplemented pin driven");
  // An input-only neighbour never steals the pad data
  a_input_only_port: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (pad.data & INPUT_ONLY) == ($past(output_latch) & INPUT_ONLY))
    else $error("input-only pin lost to peripheral");
  a_dir_output_on: assert property (@(posedge pclk) disable iff (!presetn)
    (!periph_owns[2] && !pin_direction[2]) |=> !pad.oe_n[2])
    else $error("output pin not driven");
  // The converter never sees a pin that the port drives
  a_adc_needs_input: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (adc_source & ~$past(pin_direction)) == 16'h0000)
    else $error("driven pin offered to converter");

  ////////////////////////////////////////////////////////////////////////////
  // Status flag checks: sticky, read-clear, set wins
  a_stat_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (s_stat_clear and !cn_event && !wake_event) |=> irq_status == 2'b00)
    else $error("status not cleared by read");
  a_set_wins_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (s_stat_clear and cn_event) |=> irq_status[`SPIO_STAT_CN_BIT])
    else $error("read clear beat a new change");
  a_stat_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_status[`SPIO_STAT_CN_BIT] && !(rd && pready && hit_stat)) |=> irq_status[`SPIO_STAT_CN_BIT])
    else $error("change flag dropped");
  // A change seen while asleep shows up once clocks run again
  a_wake_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    wake_event |=> irq_status[`SPIO_STAT_WAKE_BIT])
    else $error("wake did not set flag");

endmodule // spio_port
`default_nettype wire

// ---- spio_pins_model.sv ----
// Board-side model of the pins that face the shared parallel I/O port
`timescale 1ns/1ps
`default_nettype none

module spio_pins_model (
  // Pad controls from the port
  input  wire spio_pkg::spio_pad_s pad,
  // External sources on the board
  input  wire logic [15:0]         ext_lvl,
  input  wire logic [15:0]         ext_drv,
  // Levels seen back at the port
  output logic      [15:0]         pad_in
);
  // The pad driver wins, then an external source, then the board pull-up,
  // so a released pin never repeats the last driven value by accident
  always_comb
  begin
    for (int i = 0; i < 16; i++)
      pad_in[i] = !pad.oe_n[i] ? pad.data[i] : (ext_drv[i] ? ext_lvl[i] : 1'b1);
  end
endmodule // spio_pins_model

`default_nettype wire

// ---- tb.sv ----
// Self-checking testbench for the shared parallel I/O port
`timescale 1ns/1ps
`default_nettype none
`include "spio_defines.svh"

module tb;
  localparam logic [15:0] IMPL = 16'h7fff;
  logic                   pclk, presetn, psel, penable, pwrite, sleep;
  logic                   pready, pslverr, irq, err;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, rd;
  logic [15:0]            pad_in, adc_source, ext_lvl, ext_drv;
  logic [21:0]            cn;
  spio_pkg::spio_periph_s periph;
  spio_pkg::spio_pad_s    pad;
  int                     n_mismatch, checked, cycles;

  spio_port #(.NCN(22), .IMPL_MASK(IMPL), .INPUT_ONLY(16'h0001)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .periph(periph), .pad(pad), .adc_source(adc_source),
    .change_notify_input(cn), .sleep(sleep), .irq(irq));
  spio_pins_model pins (.pad(pad), .ext_lvl(ext_lvl), .ext_drv(ext_drv), .pad_in(pad_in));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and a cycle ceiling so a hung handshake still ends the run
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_mismatch++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench's cycle ceiling ends a wait that never answers
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Bounded wait for the interrupt line to reach a level
  task automatic wirq(input logic e);
    for (int n = 0; n < 20 && irq !== e; n++)
      @(posedge pclk);
    chk(32'(irq), 32'(e));
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, sleep, paddr, pwdata} = '0;
    {ext_lvl, ext_drv, cn, periph} = {16'ha5a5, 16'hffff, 22'h0, 64'h0};
    repeat (16) @(posedge pclk);
    chk(32'(pad.oe_n), 32'h0000ffff);
    presetn <= 1'b1;
    rdc(`SPIO_OFF_DIR, 32'(IMPL));
    rdc(`SPIO_OFF_LVL, 32'(16'ha5a5 & IMPL));
    apb(1'b1, `SPIO_OFF_LAT, 32'hffff);
    rdc(`SPIO_OFF_LAT, 32'(IMPL));
    apb(1'b1, `SPIO_OFF_LVL, 32'h1234);
    rdc(`SPIO_OFF_LAT, 32'h1234);
    apb(1'b1, 12'h01c, 32'h0);
    chk(32'(err), 32'h1);
    $display("test registers done");
    // Port drives from the latch, then peripherals take some pins
    ext_drv <= 16'h0;
    apb(1'b1, `SPIO_OFF_DIR, 32'h0);
    repeat (4) @(posedge pclk);
    chk(32'(pad.data & IMPL), 32'h1234);
    chk(32'(pad.oe_n & IMPL), 32'h0);
    periph <= {16'hff01, 16'h0f01, 16'hffff, 16'h0301};
    repeat (4) @(posedge pclk);
    chk(32'(pad.data & IMPL), 32'h1f34);
    chk(32'(pad.oe_n & IMPL), 32'h0c00);
    rdc(`SPIO_OFF_LVL, 32'h1f34);
    $display("test sharing done");
    // Analog pins: inputs first, then read masking and converter offer
    periph <= 64'h0;
    {ext_drv, ext_lvl} <= {16'hffff, 16'ha5a5};
    apb(1'b1, `SPIO_OFF_DIR, 32'hffff);
    apb(1'b1, `SPIO_OFF_ANA, 32'h00ff);
    repeat (4) @(posedge pclk);
    rdc(`SPIO_OFF_LVL, 32'h2500);
    chk(32'(adc_source), 32'h00ff);
    apb(1'b1, `SPIO_OFF_DIR, 32'hff0f);
    repeat (2) @(posedge pclk);
    chk(32'(adc_source), 32'h000f);
    $display("test analog done");
    // Change notification, mask, read-clear and sleep wake
    apb(1'b1, `SPIO_OFF_CNEN, 32'h200008);
    cn[3] <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(32'(irq), 32'h0);
    rdc(`SPIO_OFF_IRQ_STAT, 32'h1);
    apb(1'b1, `SPIO_OFF_IRQ_MASK, 32'h3);
    cn[5] <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(32'(irq), 32'h0);
    cn[21] <= 1'b1;
    wirq(1'b1);
    rdc(`SPIO_OFF_IRQ_STAT, 32'h1);
    wirq(1'b0);
    sleep <= 1'b1;
    repeat (3) @(posedge pclk);
    cn[3] <= 1'b0;
    repeat (3) @(posedge pclk);
    sleep <= 1'b0;
    wirq(1'b1);
    apb(1'b0, `SPIO_OFF_IRQ_STAT, 32'h0);
    chk(rd & 32'h2, 32'h2);
    $display("test change notify done");
    results();
  end
endmodule // tb

`default_nettype wire
